// >>> src/lsm_pkg.sv
/*
 line side mux package: offsets, fields, timing, mode types.
 assumes a 100 MHz system clock.
*/
package lsm_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MCLK_IDLE_NS  = 2000;
   localparam int MCLK_IDLE_CYC =
      (MCLK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TDN_HOLD_CYC  = 16;
   localparam int DPLL_OVERSMP  = 16;
   localparam int T1_DPLL_KHZ   = 24704;
   localparam int E1_DPLL_KHZ   = 32768;
   // register byte offsets
   localparam logic [7:0] OFS_GCFG = 8'h00;
   localparam logic [7:0] OFS_RSEL = 8'h04;
   localparam logic [7:0] OFS_SSEL = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   // global config fields
   localparam int GC_CODE = 0;
   localparam int GC_TS   = 1;
   localparam int GC_CVEN = 4;
   localparam logic [4:0] GC_RST = 5'h00;
   // status fields
   localparam int ST_CV   = 0;
   localparam int ST_AMI  = 1;
   localparam int ST_E1   = 2;
   localparam int ST_MC   = 3;
   localparam int ST_MODE = 6;
   // template codes up to this value select E1
   localparam logic [2:0] TS_E1_MAX = 3'h2;
   // synchroniser vector positions
   localparam int SW = 15;
   localparam int IX_MC = 0;
   localparam int IX_TC = 1;
   localparam int IX_TP = 2;
   localparam int IX_TN = 3;
   localparam int IX_RC = 4;
   localparam int IX_RP = 5;
   localparam int IX_RN = 6;
   localparam int IX_SP = 7;
   localparam int IX_SN = 8;
   localparam int IX_LC = 9;
   localparam int IX_CE = 10;
   localparam int IX_HM = 11;
   localparam int IX_TS = 12;

   typedef enum logic [4:0] {
      MD_DCR  = 5'b00001,
      MD_DDR  = 5'b00010,
      MD_SR1  = 5'b00100,
      MD_SR2  = 5'b01000,
      MD_OFF  = 5'b10000
   } lsm_mode_type;

   typedef enum logic [2:0] {
      MC_RUN  = 3'b001,
      MC_HIGH = 3'b010,
      MC_LOW  = 3'b100
   } lsm_mclk_type;

   // pulse kinds of the line encoder
   typedef enum logic [1:0] {
      PK_ZERO = 2'h0,
      PK_BIP  = 2'h1,
      PK_VIOL = 2'h2
   } lsm_pulse_type;
endpackage : lsm_pkg

// >>> src/lsm_sys_mux.sv
/*
 one channel of the system side interface mux with line coder.
 assumes pins arrive unsynchronised and a wishbone classic master.
*/
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
// Function
// - T1 or E1 choice is global, from template pins or register.
// - channel supports single rail, dual rail recovery, dual rail raw.
// - dual rail passes tx rails to line, rx rails and clock out.
// - after reset the channel is dual rail with clock recovery.
// - raw mode drives rx clock with xor of the two slicer outputs.
// - raw mode puts slicer outputs on rx rails without retiming.
// - single rail enables coder and flags violations on negative rail.
// - negative tx pin high over 16 tx clocks selects single rail one.
// - single rail two inserts a bipolar violation on request with AMI.
// - host bits recovery and single rail select pick the mode.
// - master clock high forces dual rail raw mode on every channel.
// - master clock low powers the receiver down; tx follows tx clock.
// - edge select picks rx clock and serial clock active edges.
// - rx outputs are active high, launched on active rx clock edge.
// - in raw mode edge select sets slicer output polarity.
// - serial data in is active high, sampled on serial clock rise.
// - tx data and insert are active high, sampled on tx clock fall.
// - rx data is decoded in single rail or sent undecoded NRZ.
// - code violations set a sticky status bit, enabled by the config register.
// - recovery loop runs at sixteen times line rate, T1 or E1.
// - line code bit or pin low is B8ZS/HDB3, high is AMI.
`timescale 1ns/1ps
module lsm_sys_mux #(
   parameter int IDLE_CYC = lsm_pkg::MCLK_IDLE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        host_mode_i,
   input  wire logic        master_clock_i,
   input  wire logic [2:0]  template_select_i,
   input  wire logic        line_code_pin_i,
   input  wire logic        clock_edge_select_i,
   input  wire logic        tx_chan_clock_i,
   input  wire logic        tx_pos_rail_in_i,
   input  wire logic        tx_neg_rail_in_i,
   input  wire logic        slicer_pos_i,
   input  wire logic        slicer_neg_i,
   input  wire logic        dpll_clock_i,
   input  wire logic        dpll_pos_i,
   input  wire logic        dpll_neg_i,
   output logic             line_tx_tip_o,
   output logic             line_tx_ring_o,
   output logic             rx_pos_rail_out_o,
   output logic             rx_neg_rail_out_o,
   output logic             rx_recovered_clock_o,
   output logic             rx_power_down_o,
   output logic             e1_select_o,
   output logic             serial_out_fall_o,
   output lsm_pkg::lsm_mode_type mode_o
);
   import lsm_pkg::*;

   logic [SW-1:0] s1_reg, s2_reg, s3_reg, pv_reg, pr_reg;
   logic          tc_fall, rc_rise, rc_fall, act_edge;
   lsm_mclk_type  mc_reg;
   logic [15:0]   idle_reg;
   logic [4:0]    gcfg_reg;
   logic          recovery_select_reg, single_rail_select_reg;
   logic          cv_st_reg;
   logic [4:0]    tdn_cnt_reg;
   logic          stuck, host, e1, ami, ces, sgl;
   logic [2:0]    ts;
   lsm_mode_type  mode_reg, mode_next;
   logic [7:0]    dl_reg;
   logic          ins_reg, lp_reg, par_reg;
   logic [3:0]    sub_reg, len, sub_next;
   logic          ob, zwin;
   lsm_pulse_type kind;
   logic [7:0]    hm_reg, hv_reg, nm, nv;
   logic          rlp_reg, dec_reg, cv_reg, dp_reg, dn_reg;
   logic          rmk, rvi;
   logic          wr, hit_g;
   ////////////////////////////////////////////////////////////
   // pin synchronisers: change accepted when stages 2, 3 agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {s1_reg, s2_reg, s3_reg, pv_reg, pr_reg} <= '0;
      end else begin
         s1_reg <= {template_select_i, host_mode_i,
                    clock_edge_select_i, line_code_pin_i,
                    slicer_neg_i, slicer_pos_i, dpll_neg_i,
                    dpll_pos_i, dpll_clock_i, tx_neg_rail_in_i,
                    tx_pos_rail_in_i, tx_chan_clock_i,
                    master_clock_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pv_reg <= (pv_reg & (s2_reg ^ s3_reg))
                 | (s3_reg & ~(s2_reg ^ s3_reg));
         pr_reg <= pv_reg;
      end
   end
   // edge events on the filtered pins
   assign tc_fall = pr_reg[IX_TC] & ~pv_reg[IX_TC];
   assign rc_rise = ~pr_reg[IX_RC] & pv_reg[IX_RC];
   assign rc_fall = pr_reg[IX_RC] & ~pv_reg[IX_RC];
   assign ces     = pv_reg[IX_CE];
   assign act_edge = ces ? rc_rise : rc_fall;
   assign host    = pv_reg[IX_HM];

   ////////////////////////////////////////////////////////////
   // master clock watch: running, stuck high or stuck low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mc_reg   <= MC_RUN;
         idle_reg <= '0;
      end else if (pr_reg[IX_MC] ^ pv_reg[IX_MC]) begin
         mc_reg   <= MC_RUN;
         idle_reg <= '0;
      end else if (idle_reg >= 16'(IDLE_CYC)) begin
         mc_reg   <= pv_reg[IX_MC] ? MC_HIGH : MC_LOW;
      end else begin
         idle_reg <= idle_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////
   // global choices, same for every channel
   assign ts  = host ? gcfg_reg[GC_TS +: 3]
                     : pv_reg[IX_TS +: 3];
   assign e1  = (ts <= TS_E1_MAX);
   assign ami = host ? gcfg_reg[GC_CODE]
                     : pv_reg[IX_LC];
   // high count of the negative tx pin, cleared when it drops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tdn_cnt_reg <= '0;
      end else if (tc_fall) begin
         if (!pv_reg[IX_TN]) begin
            tdn_cnt_reg <= '0;
         end else if (tdn_cnt_reg != 5'h1f) begin
            tdn_cnt_reg <= tdn_cnt_reg + 5'h01;
         end
      end
   end
   assign stuck = (tdn_cnt_reg > 5'(TDN_HOLD_CYC));

   ////////////////////////////////////////////////////////////
   // interface mode selection
   always_comb begin
      if (mc_reg == MC_LOW) begin
         mode_next = MD_OFF;
      end else if (mc_reg == MC_HIGH) begin
         mode_next = MD_DDR;
      end else if (stuck) begin
         mode_next = MD_SR1;
      end else if (host && single_rail_select_reg
                   && !recovery_select_reg) begin
         mode_next = MD_SR2;
      end else if (host && recovery_select_reg
                   && !single_rail_select_reg) begin
         mode_next = MD_DDR;
      end else begin
         mode_next = MD_DCR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= MD_DCR;
      end else begin
         mode_reg <= mode_next;
      end
   end
   assign sgl = (mode_reg == MD_SR1) || (mode_reg == MD_SR2);

   ////////////////////////////////////////////////////////////
   // encoder: lookahead length and substitution slots
   always_comb begin
      len  = ami ? 4'h1 : (e1 ? 4'h4 : 4'h8);
      ob   = dl_reg[len[2:0] - 3'h1];
      zwin = e1 ? (dl_reg[3:0] == 4'h0) : (dl_reg == 8'h00);
      kind = PK_ZERO;
      sub_next = 4'h0;
      if (sub_reg != 4'h0) begin
         sub_next = sub_reg - 4'h1;
         if (e1) begin
            if (sub_reg == 4'h4 && !par_reg) kind = PK_BIP;
            if (sub_reg == 4'h1) kind = PK_VIOL;
         end else begin
            if (sub_reg == 4'h5 || sub_reg == 4'h2) kind = PK_VIOL;
            if (sub_reg == 4'h4 || sub_reg == 4'h1) kind = PK_BIP;
         end
      end else if (!ami && zwin) begin
         sub_next = len - 4'h1;
         if (e1 && !par_reg) kind = PK_BIP;
      end else if (ob) begin
         kind = ins_reg ? PK_VIOL : PK_BIP;
      end
   end
   // transmit path, stepped on the tx clock falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {dl_reg, ins_reg, lp_reg, par_reg, sub_reg} <= '0;
         {line_tx_tip_o, line_tx_ring_o} <= 2'h0;
      end else if (tc_fall) begin
         if (!sgl) begin
            line_tx_tip_o <= pv_reg[IX_TP];
            line_tx_ring_o <= pv_reg[IX_TN];
            sub_reg <= '0;
         end else begin
            dl_reg <= {dl_reg[6:0], pv_reg[IX_TP]};
            ins_reg <= pv_reg[IX_TN] && ami
                       && (mode_reg == MD_SR2);
            sub_reg <= sub_next;
            line_tx_tip_o <= 1'b0;
            line_tx_ring_o <= 1'b0;
            if (kind == PK_BIP) begin
               line_tx_tip_o <= ~lp_reg;
               line_tx_ring_o <= lp_reg;
               lp_reg <= ~lp_reg;
               par_reg <= ~par_reg;
            end else if (kind == PK_VIOL) begin
               line_tx_tip_o <= lp_reg;
               line_tx_ring_o <= ~lp_reg;
               par_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // decoder history with substitution removal
   always_comb begin
      rmk = pv_reg[IX_RP] | pv_reg[IX_RN];
      rvi = rmk && (pv_reg[IX_RP] == rlp_reg);
      nm = {hm_reg[6:0], rmk};
      nv = {hv_reg[6:0], rvi};
      if (!ami && e1 && nv[0] && nm[2:1] == 2'h0) begin
         nm[3:0] = 4'h0;
         nv[3:0] = 4'h0;
      end
      if (!ami && !e1 && nm == 8'h1b && nv[4] && nv[1]) begin
         nm = 8'h00;
         nv = 8'h00;
      end
   end
   // receive sample on the recovered clock rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {hm_reg, hv_reg, rlp_reg, dec_reg, cv_reg, dp_reg, dn_reg} <= '0;
      end else if (rc_rise) begin
         hm_reg <= nm;
         hv_reg <= nv;
         if (rmk) rlp_reg <= pv_reg[IX_RP];
         dec_reg <= nm[len[2:0] - 3'h1];
         cv_reg <= nv[len[2:0] - 3'h1];
         dp_reg <= pv_reg[IX_RP];
         dn_reg <= pv_reg[IX_RN];
      end
   end
   ////////////////////////////////////////////////////////////
   // receive outputs per mode
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_reg == MD_OFF) begin
         {rx_pos_rail_out_o, rx_neg_rail_out_o} <= 2'h0;
         rx_recovered_clock_o <= 1'h0;
      end else if (mode_reg == MD_DDR) begin
         rx_pos_rail_out_o <= pv_reg[IX_SP] ^ ~ces;
         rx_neg_rail_out_o <= pv_reg[IX_SN] ^ ~ces;
         rx_recovered_clock_o <= pv_reg[IX_SP]
                                 ^ pv_reg[IX_SN];
      end else begin
         rx_recovered_clock_o <= pv_reg[IX_RC];
         if (act_edge) begin
            rx_pos_rail_out_o <= sgl ? dec_reg : dp_reg;
            rx_neg_rail_out_o <= sgl ? cv_reg : dn_reg;
         end
      end
   end
   // side outputs: loop rate, serial edges, mode, power down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {e1_select_o, serial_out_fall_o, rx_power_down_o} <= 3'h0;
         mode_o <= MD_DCR;
      end else begin
         e1_select_o <= e1;
         serial_out_fall_o <= ces;
         rx_power_down_o <= (mode_reg == MD_OFF);
         mode_o <= mode_reg;
      end
   end

   ////////////////////////////////////////////////////////////
   // wishbone slave, ack one cycle after the request
   // writes land at the edge that sees ack high, as the master expects
   assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                  && wb_sel_i[0];
   assign hit_g = (wb_adr_i == OFS_GCFG);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (wb_adr_i)
            OFS_GCFG: wb_dat_o <= {27'h0, gcfg_reg};
            OFS_RSEL: wb_dat_o <= {31'h0, recovery_select_reg};
            OFS_SSEL: wb_dat_o <= {31'h0, single_rail_select_reg};
            OFS_STAT: wb_dat_o <= {21'h0, mode_reg, mc_reg,
                                   e1, ami, cv_st_reg};
            default:  wb_dat_o <= '0;
         endcase
      end
   end
   // config registers and sticky violation status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gcfg_reg <= GC_RST;
         {recovery_select_reg, single_rail_select_reg, cv_st_reg} <= 3'h0;
      end else begin
         if (wr && hit_g) gcfg_reg <= wb_dat_i[4:0];
         if (wr && wb_adr_i == OFS_RSEL)
            recovery_select_reg <= wb_dat_i[0];
         if (wr && wb_adr_i == OFS_SSEL)
            single_rail_select_reg <= wb_dat_i[0];
         if (rc_rise && sgl && gcfg_reg[GC_CVEN]
             && nv[len[2:0] - 3'h1]) begin
            cv_st_reg <= 1'b1;
         end else if (wr && wb_adr_i == OFS_STAT
                      && wb_dat_i[ST_CV]) begin
            cv_st_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_tdn_held;
      tc_fall && pv_reg[IX_TN] ##1 stuck;
   endsequence
   // master clock must still run in the cycle the count is seen
   property p_sr1_entry;
      s_tdn_held ##0 mc_reg == MC_RUN |=> mode_reg == MD_SR1;
   endproperty
   a_sr1_entry: assert property (p_sr1_entry)
      else $error("single rail one not entered");
   property p_cnt_clear;
      tc_fall && !pv_reg[IX_TN] |=> tdn_cnt_reg == 5'h00;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear)
      else $error("high count not cleared");
   property p_mc_high;
      mc_reg == MC_HIGH |=> mode_reg == MD_DDR;
   endproperty
   a_mc_high: assert property (p_mc_high)
      else $error("raw mode not forced");
   property p_mc_low;
      mode_reg == MD_OFF |=> !rx_pos_rail_out_o
         && !rx_neg_rail_out_o && !rx_recovered_clock_o;
   endproperty
   a_mc_low: assert property (p_mc_low)
      else $error("receiver outputs active while off");
   property p_raw_clock;
      mode_reg == MD_DDR |=> rx_recovered_clock_o ==
         ($past(pv_reg[IX_SP]) ^ $past(pv_reg[IX_SN]));
   endproperty
   a_raw_clock: assert property (p_raw_clock)
      else $error("raw clock not rail xor");
   property p_raw_pol;
      mode_reg == MD_DDR && !ces |=>
         rx_pos_rail_out_o == !$past(pv_reg[IX_SP]);
   endproperty
   a_raw_pol: assert property (p_raw_pol)
      else $error("raw polarity wrong");
   property p_host_sel;
      mc_reg == MC_RUN && host && !stuck
      && recovery_select_reg && !single_rail_select_reg
      |=> mode_reg == MD_DDR;
   endproperty
   a_host_sel: assert property (p_host_sel)
      else $error("host select ignored");
   property p_dual_tx;
      tc_fall && !sgl |=> line_tx_tip_o == $past(pv_reg[IX_TP])
         && line_tx_ring_o == $past(pv_reg[IX_TN]);
   endproperty
   a_dual_tx: assert property (p_dual_tx)
      else $error("dual rail tx not passed");
   property p_ack_drop;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack held two cycles");
endmodule : lsm_sys_mux

// >>> test/lsm_framer_model.sv
/*
 framer side model: makes the channel tx clock, launches tx rails,
 and counts line marks seen at each tx clock fall.
 assumes the bench sets the rail bits and the run level.
*/
`timescale 1ns/1ps
module lsm_framer_model (
   input  wire logic run_i,
   input  wire logic pos_i,
   input  wire logic neg_i,
   input  wire logic tip_i,
   input  wire logic ring_i,
   output logic      tx_clk_o,
   output logic      pos_o,
   output logic      neg_o,
   output int        tip_cnt_o,
   output int        ring_cnt_o
);
   ////////////////////////////////////////////////////////////////////
   // tx clock stands high between frames, 80 ns period while running
   initial begin
      tx_clk_o = 1'b1;
      pos_o = 1'b0;
      neg_o = 1'b0;
      tip_cnt_o = 0;
      ring_cnt_o = 0;
   end
   always begin
      #40;
      if (run_i || !tx_clk_o) begin
         tx_clk_o = ~tx_clk_o;
      end
   end
   // rails change on the rise so they are steady at the sampling fall
   always @(posedge tx_clk_o) begin
      pos_o <= pos_i;
      neg_o <= neg_i;
   end
   // line marks counted where the line output stands
   always @(negedge tx_clk_o) begin
      tip_cnt_o <= tip_cnt_o + int'(tip_i);
      ring_cnt_o <= ring_cnt_o + int'(ring_i);
   end
endmodule : lsm_framer_model

// >>> test/tb.sv
/*
 bench for one channel mux: register rows, then hand-written cases.
 assumes the framer model and a 100 MHz clock.
*/
`timescale 1ns/1ps
module tb;
   import lsm_pkg::*;
   typedef struct {
      logic [7:0]   adr;
      logic [31:0]  dat;
      logic [31:0]  rd;
      lsm_mode_type md;
      logic         e1;
   } lsm_row_type;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, q, wb_dat_o;
   logic wb_ack_o, mclk = 1'b0, hm = 1'b1, ce = 1'b1, sp = 1'b0;
   logic sn = 1'b0, run = 1'b0, pos = 1'b0, neg = 1'b0;
   logic rck = 1'b0, rp = 1'b0, rn = 1'b0;
   logic tx_clk, tp, tn, tip, ring, rxp, rxn, rxc, pdn, e1, sof;
   logic [1:0] mc_mode = 2'd0, mc_div = 2'd0;
   lsm_mode_type mode_o;
   int errors = 0, num_checks = 0, tc, rc, tc2, rc2;
   lsm_row_type rows [10] = '{
      '{8'h00, 32'h0, 32'h0, MD_DCR, 1'b1},
      '{8'h00, 32'h6, 32'h6, MD_DCR, 1'b0},
      '{8'h04, 32'h1, 32'h1, MD_DDR, 1'b0},
      '{8'h04, 32'h0, 32'h0, MD_DCR, 1'b0},
      '{8'h08, 32'h1, 32'h1, MD_SR2, 1'b0},
      '{8'h04, 32'h1, 32'h1, MD_DCR, 1'b0},
      '{8'h04, 32'h0, 32'h0, MD_SR2, 1'b0},
      '{8'h10, 32'hff, 32'h0, MD_SR2, 1'b0},
      '{8'h00, 32'h7, 32'h7, MD_SR2, 1'b0},
      '{8'h0c, 32'h1, 32'h20a, MD_SR2, 1'b0}};
   ////////////////////////////////////////////////////////////////////
   // clock, and master clock running, held high or held low
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      mc_div <= mc_div + 2'd1;
      if (mc_mode != 2'd0) begin
         mclk <= (mc_mode == 2'd1);
      end else if (mc_div == 2'd0) begin
         mclk <= ~mclk;
      end
   end
   lsm_sys_mux #(.IDLE_CYC(20)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .host_mode_i(hm), .master_clock_i(mclk),
      .template_select_i(3'h0), .line_code_pin_i(1'b0),
      .clock_edge_select_i(ce), .tx_chan_clock_i(tx_clk),
      .tx_pos_rail_in_i(tp), .tx_neg_rail_in_i(tn), .slicer_pos_i(sp),
      .slicer_neg_i(sn), .dpll_clock_i(rck), .dpll_pos_i(rp),
      .dpll_neg_i(rn), .line_tx_tip_o(tip), .line_tx_ring_o(ring),
      .rx_pos_rail_out_o(rxp), .rx_neg_rail_out_o(rxn),
      .rx_recovered_clock_o(rxc), .rx_power_down_o(pdn),
      .e1_select_o(e1), .serial_out_fall_o(sof), .mode_o(mode_o));
   lsm_framer_model far (.run_i(run), .pos_i(pos), .neg_i(neg),
      .tip_i(tip), .ring_i(ring), .tx_clk_o(tx_clk), .pos_o(tp),
      .neg_o(tn), .tip_cnt_o(tc), .ring_cnt_o(rc));
   ////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // one classic cycle, entered just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      r = wb_dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wait_mode(input lsm_mode_type m);
      int n;
      n = 0;
      while (mode_o !== m && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(mode_o), 32'(m));
   endtask : wait_mode
   task automatic frames(input int n);
      repeat (n) @(negedge tx_clk);
      @(posedge clk_i);
   endtask : frames
   // one recovered bit: rails set, then a full recovered clock period
   task automatic rx_bit(input logic p, input logic n);
      rp <= p;
      rn <= n;
      repeat (8) @(posedge clk_i);
      rck <= 1'b1;
      repeat (8) @(posedge clk_i);
      rck <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : rx_bit
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////
   // watchdog well beyond the expected run
   initial begin
      #500000;
      errors++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(mode_o), 32'(MD_DCR));
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, rows[i].dat, q);
         wb(1'b0, rows[i].adr, 32'h0, q);
         chk(q, rows[i].rd);
         wait_mode(rows[i].md);
         chk(32'(e1), 32'(rows[i].e1));
      end
      // single rail two, ami: marks alternate, inserts repeat polarity
      pos <= 1'b1;
      run <= 1'b1;
      frames(4);
      tc2 = tc; rc2 = rc;
      frames(8);
      chk(32'(tc - tc2), 32'h4);
      chk(32'(rc - rc2), 32'h4);
      neg <= 1'b1;
      frames(2);
      tc2 = tc; rc2 = rc;
      frames(8);
      chk(32'((tc - tc2) == 0 || (rc - rc2) == 0), 32'h1);
      neg <= 1'b0;
      frames(2);
      wb(1'b1, OFS_SSEL, 32'h0, q);
      wait_mode(MD_DCR);
      // dual rail passes the rails straight to the line
      frames(3);
      chk({30'h0, tip, ring}, 32'h2);
      pos <= 1'b0;
      neg <= 1'b1;
      frames(3);
      chk({30'h0, tip, ring}, 32'h1);
      frames(10);
      chk(32'(mode_o), 32'(MD_DCR));
      frames(8);
      wait_mode(MD_SR1);
      neg <= 1'b0;
      frames(3);
      wait_mode(MD_DCR);
      // recovered path: rails follow one active rise behind
      rx_bit(1'b1, 1'b0);
      rx_bit(1'b1, 1'b0);
      chk({29'h0, rxp, rxn, rxc}, 32'h4);
      rx_bit(1'b0, 1'b1);
      rx_bit(1'b0, 1'b1);
      chk({29'h0, rxp, rxn, rxc}, 32'h2);
      run <= 1'b0;
      // master clock high: raw slicing, edge select as polarity
      mc_mode <= 2'd1;
      wait_mode(MD_DDR);
      for (int k = 0; k < 8; k++) begin
         sp <= k[0];
         sn <= k[1];
         ce <= k[2];
         repeat (10) @(posedge clk_i);
         chk({rxp, rxn, rxc, sof}, {k[0] ~^ k[2], k[1] ~^ k[2],
             k[0] ^ k[1], k[2]});
      end
      // master clock low: receiver off
      mc_mode <= 2'd2;
      wait_mode(MD_OFF);
      chk({pdn, rxp, rxn}, 32'h4);
      // reset again in mid-run
      rst_i <= 1'b1;
      mc_mode <= 2'd0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(mode_o), 32'(MD_DCR));
      wb(1'b0, OFS_GCFG, 32'h0, q);
      chk(q, 32'h0);
      chk(32'(e1), 32'h1);
      wait_mode(MD_DCR);
      wrap_up();
   end
endmodule : tb
